// File: asfa_host_model.sv
`timescale 1ns/1ps
module asfa_host_model
   import asfa_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Serial pins toward the device
   output logic cs_n_out,
   output logic sclk_out,
   output logic sdi_out,
   output logic daisy_out,
   input wire logic sdo_in,
   // Captured read data
   output logic [19:0] rx_out,
   output logic pre_or_out
);
   // Deselected, serial clock parked low between frames
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
      daisy_out = 1'b0;
      rx_out = 20'h0;
      pre_or_out = 1'b0;
   end

   // Wait whole system clock cycles
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // One frame of nf falling edges; sdo sampled just before each fall
   task automatic frame(input logic [CMD_W-1:0] cmd, input int nf, input logic dz);
      tick(1);
      rx_out <= 20'h0;
      pre_or_out <= 1'b0;
      daisy_out <= dz;
      sdi_out <= cmd[CMD_W-1];
      cs_n_out <= 1'b0;
      // Edge 16 lands far beyond the conversion time
      tick(8);
      for (int k = 1; k <= nf; k++) begin
         sclk_out <= 1'b1;
         tick(4);
         if (k > 16) begin
            rx_out <= {rx_out[18:0], sdo_in};
         end else begin
            pre_or_out <= pre_or_out | sdo_in;
         end
         sclk_out <= 1'b0;
         tick(4);
         // Garbage after the command shows that sdi is ignored
         if (k < 16) begin
            sdi_out <= cmd[CMD_W-1-k];
         end else begin
            sdi_out <= ~sdi_out;
         end
      end
      cs_n_out <= 1'b1;
      tick(8);
   endtask
endmodule

// File: asfa_limit_mem.sv
`timescale 1ns/1ps
module asfa_limit_mem
   import asfa_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Write side
   input wire logic wr_en_in,
   input wire logic [CH_W-1:0] wr_addr_in,
   input wire asfa_limits_type wr_data_in,
   // Read side
   input wire logic [CH_W-1:0] rd_addr_in,
   output asfa_limits_type rd_data_out
);

   asfa_limits_type mem [CH_N];

   // One limit set per channel, registered read
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end

endmodule

// File: asfa_pkg.sv
package asfa_pkg;

   // Widths
   localparam int RES_W = 18;
   localparam int CMD_W = 16;
   localparam int CH_N = 8;
   localparam int CH_W = 3;
   localparam int CNT_W = 5;
   localparam int EXT_W = 21;
   localparam int PV_W = 32;

   // Falling serial clock edge that closes the command word
   localparam logic [CNT_W-1:0] CMD_LAST_EDGE = 5'h0f;

   // Reset/power-down pin timing, in ns, turned into cycles at 40 MHz
   localparam int CLK_PERIOD_PS = 25000;
   localparam int RST_MIN_NS = 40;
   localparam int RST_MAX_NS = 100;
   localparam int PD_MIN_NS = 400;
   localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RST_MAX_CYC = (RST_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int PD_MIN_CYC = (PD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [CNT_W-1:0] RST_MIN_CNT = CNT_W'(RST_MIN_CYC);
   localparam logic [CNT_W-1:0] PD_MIN_CNT = CNT_W'(PD_MIN_CYC);

   // Alarm limit offsets
   localparam logic signed [EXT_W-1:0] HI_CLR_OFS = 21'sh2;
   localparam logic signed [EXT_W-1:0] LO_SET_OFS = 21'sh1;
   localparam logic signed [EXT_W-1:0] LO_CLR_OFS = 21'sh1;

   // Read data after an aborted frame
   localparam logic [RES_W-1:0] INVALID_FILL = 18'h3ffff;

   // Input range codes
   localparam logic [2:0] RNG_BI_2P5 = 3'h0;
   localparam logic [2:0] RNG_BI_1P25 = 3'h1;
   localparam logic [2:0] RNG_BI_0P625 = 3'h2;
   localparam logic [2:0] RNG_UNI_2P5 = 3'h5;
   localparam logic [2:0] RNG_UNI_1P25 = 3'h6;

   // Code step with a 4.096 V reference, in picovolts
   localparam logic [PV_W-1:0] LSB_WIDE_PV = 32'h04a8_17c8;
   localparam logic [PV_W-1:0] LSB_MID_PV = 32'h0254_0be4;
   localparam logic [PV_W-1:0] LSB_NARROW_PV = 32'h012a_05f2;

   typedef struct packed {
      logic [RES_W-1:0] hi_thr;
      logic [RES_W-1:0] hi_hyst;
      logic [RES_W-1:0] lo_thr;
      logic [RES_W-1:0] lo_hyst;
   } asfa_limits_type;

   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_CMD = 2'b01,
      FR_DATA = 2'b11
   } asfa_frame_type;

   // Step size = span / 2^18 for each range
   function automatic logic [PV_W-1:0] asfa_lsb_step(input logic [2:0] rng);
      logic [PV_W-1:0] step;
      step = LSB_MID_PV;
      case (rng)
         RNG_BI_2P5: step = LSB_WIDE_PV;
         RNG_BI_0P625, RNG_UNI_1P25: step = LSB_NARROW_PV;
         default: step = LSB_MID_PV;
      endcase
      return step;
   endfunction

endpackage

// File: asfa_top.sv
`timescale 1ns/1ps
module asfa_top
   import asfa_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Serial pins
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   input wire logic daisy_in,
   input wire logic reset_powerdown_n_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   output logic alarm_out,
   // Converter core
   input wire logic conv_valid_in,
   input wire logic [RES_W-1:0] conv_result_in,
   input wire logic [2:0] conv_range_in,
   output logic conv_start_out,
   output logic [CH_W-1:0] conv_channel_out,
   output logic [PV_W-1:0] lsb_step_out,
   // Configuration and flags
   input wire logic [CH_W-1:0] chan_sel_in,
   input wire logic lim_wr_in,
   input wire logic [CH_W-1:0] lim_chan_in,
   input wire asfa_limits_type lim_data_in,
   input wire logic flag_read_in,
   input wire logic [CH_W-1:0] flag_chan_in,
   output logic [CH_N-1:0] active_hi_out,
   output logic [CH_N-1:0] active_lo_out,
   output logic [CH_N-1:0] tripped_hi_out,
   output logic [CH_N-1:0] tripped_lo_out,
   // Command and mode
   output logic [CMD_W-1:0] cmd_word_out,
   output logic cmd_valid_out,
   output logic invalid_out,
   output logic power_down_state_out,
   output logic reg_reset_out
);

   // Pin synchronisers
   logic cs_s1_ff, cs_s2_ff, cs_d_ff;
   logic sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
   logic sdi_s1_ff, sdi_s2_ff, daisy_s1_ff, daisy_s2_ff;
   logic rpd_s1_ff, rpd_s2_ff;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
         cs_d_ff <= 1'b1;
         sclk_s1_ff <= 1'b0; // Parked clock level, no false edge
         sclk_s2_ff <= 1'b0;
         sclk_d_ff <= 1'b0;
         sdi_s1_ff <= 1'b0;
         sdi_s2_ff <= 1'b0;
         daisy_s1_ff <= 1'b0;
         daisy_s2_ff <= 1'b0;
         rpd_s1_ff <= 1'b1;
         rpd_s2_ff <= 1'b1;
      end else begin
         cs_s1_ff <= cs_n_in;
         cs_s2_ff <= cs_s1_ff;
         cs_d_ff <= cs_s2_ff;
         sclk_s1_ff <= sclk_in;
         sclk_s2_ff <= sclk_s1_ff;
         sclk_d_ff <= sclk_s2_ff;
         sdi_s1_ff <= sdi_in;
         sdi_s2_ff <= sdi_s1_ff;
         daisy_s1_ff <= daisy_in;
         daisy_s2_ff <= daisy_s1_ff;
         rpd_s1_ff <= reset_powerdown_n_in;
         rpd_s2_ff <= rpd_s1_ff;
      end
   end

   logic cs_fall, cs_rise, sclk_fall;
   assign cs_fall = cs_d_ff & ~cs_s2_ff;
   assign cs_rise = ~cs_d_ff & cs_s2_ff;
   assign sclk_fall = sclk_d_ff & ~sclk_s2_ff;

   // Reset/power-down pin: measure the low width in cycles
   logic [CNT_W-1:0] low_cnt_ff, nxt_low_cnt;
   logic nxt_pd, nxt_regrst;

   always_comb begin
      nxt_low_cnt = low_cnt_ff;
      nxt_pd = power_down_state_out;
      nxt_regrst = 1'b0;
      if (!rpd_s2_ff) begin
         if (low_cnt_ff != PD_MIN_CNT) begin
            nxt_low_cnt = low_cnt_ff + 5'h01;
         end
         // Long pulse: power down while the pin stays low
         nxt_pd = (nxt_low_cnt == PD_MIN_CNT);
      end else begin
         // Glitches under the least width are filtered out; the
         // band between 100 ns and 400 ns resets as well
         nxt_regrst = (low_cnt_ff >= RST_MIN_CNT);
         nxt_low_cnt = '0;
         nxt_pd = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         low_cnt_ff <= '0;
         power_down_state_out <= 1'b0;
         reg_reset_out <= 1'b0;
      end else begin
         low_cnt_ff <= nxt_low_cnt;
         power_down_state_out <= nxt_pd;
         reg_reset_out <= nxt_regrst;
      end
   end

   // Serial frame engine
   asfa_frame_type state_ff, nxt_state;
   logic [CNT_W-1:0] edge_cnt_ff, nxt_edge_cnt;
   logic [CMD_W-1:0] cmd_sr_ff, nxt_cmd_sr, nxt_cmd_word;
   logic [RES_W-1:0] shreg_ff, nxt_shreg, result_ff, load_word;
   logic [CH_W-1:0] staged_ff, nxt_staged, nxt_conv_channel;
   logic nxt_sdo, nxt_oe, nxt_conv_start, nxt_cmd_valid, nxt_invalid, nxt_alarm;
   logic frame_ok, edge16, any_trip;

   // Serial pin inputs are dead while powered down or under register reset
   assign frame_ok = ~power_down_state_out & ~reg_reset_out;
   assign edge16 = frame_ok & ~cs_fall & ~cs_rise & sclk_fall
      & (state_ff == FR_CMD) & (edge_cnt_ff == CMD_LAST_EDGE);
   // Result passes unaltered: straight binary on every range
   assign load_word = invalid_out ? INVALID_FILL : result_ff;
   assign any_trip = |{tripped_hi_out, tripped_lo_out};

   always_comb begin
      nxt_state = state_ff;
      nxt_edge_cnt = edge_cnt_ff;
      nxt_cmd_sr = cmd_sr_ff;
      nxt_cmd_word = cmd_word_out;
      nxt_shreg = shreg_ff;
      nxt_staged = staged_ff;
      nxt_conv_channel = conv_channel_out;
      nxt_sdo = sdo_out;
      nxt_oe = sdo_oe_out;
      nxt_conv_start = 1'b0;
      nxt_cmd_valid = 1'b0;
      nxt_invalid = invalid_out;
      nxt_alarm = alarm_out;
      if (!frame_ok) begin
         nxt_state = FR_IDLE;
         nxt_sdo = 1'b0;
         nxt_oe = 1'b0;
         if (reg_reset_out) begin
            nxt_staged = '0;
            nxt_conv_channel = '0;
            nxt_invalid = 1'b0;
         end
      end else if (cs_fall) begin
         // Sample the channel picked last frame; new settings apply now
         nxt_state = FR_CMD;
         nxt_edge_cnt = '0;
         nxt_conv_channel = staged_ff;
         nxt_conv_start = 1'b1;
         nxt_sdo = 1'b0;
         nxt_oe = 1'b1;
      end else if (cs_rise) begin
         // Abort before the command word is complete
         if (state_ff == FR_CMD) begin
            nxt_invalid = 1'b1;
         end
         nxt_state = FR_IDLE;
         nxt_sdo = 1'b0;
         nxt_oe = 1'b0;
      end else if (sclk_fall && state_ff == FR_CMD) begin
         nxt_edge_cnt = edge_cnt_ff + 5'h01;
         nxt_cmd_sr = {cmd_sr_ff[CMD_W-2:0], sdi_s2_ff};
         if (edge_cnt_ff == CMD_LAST_EDGE) begin
            nxt_state = FR_DATA;
            nxt_cmd_word = {cmd_sr_ff[CMD_W-2:0], sdi_s2_ff};
            nxt_cmd_valid = 1'b1;
            nxt_staged = chan_sel_in;
            nxt_invalid = 1'b0;
            // Data is only right if the host waited out the conversion
            nxt_shreg = load_word;
            nxt_sdo = load_word[RES_W-1];
            nxt_alarm = any_trip;
         end
      end else if (sclk_fall && state_ff == FR_DATA) begin
         // The sdi input is no longer looked at here; daisy shifts in
         nxt_shreg = {shreg_ff[RES_W-2:0], daisy_s2_ff};
         nxt_sdo = shreg_ff[RES_W-2];
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_ff <= FR_IDLE;
         edge_cnt_ff <= '0;
         cmd_sr_ff <= '0;
         cmd_word_out <= '0;
         shreg_ff <= '0;
         staged_ff <= '0;
         conv_channel_out <= '0;
         sdo_out <= 1'b0;
         sdo_oe_out <= 1'b0;
         conv_start_out <= 1'b0;
         cmd_valid_out <= 1'b0;
         invalid_out <= 1'b0;
         alarm_out <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         edge_cnt_ff <= nxt_edge_cnt;
         cmd_sr_ff <= nxt_cmd_sr;
         cmd_word_out <= nxt_cmd_word;
         shreg_ff <= nxt_shreg;
         staged_ff <= nxt_staged;
         conv_channel_out <= nxt_conv_channel;
         sdo_out <= nxt_sdo;
         sdo_oe_out <= nxt_oe;
         conv_start_out <= nxt_conv_start;
         cmd_valid_out <= nxt_cmd_valid;
         invalid_out <= nxt_invalid;
         alarm_out <= nxt_alarm;
      end
   end

   // Per-channel limits, read for the channel under conversion
   asfa_limits_type lim;

   asfa_limit_mem asfa_limit_mem_inst (
      .clk_in(clk_in),
      .wr_en_in(lim_wr_in),
      .wr_addr_in(lim_chan_in),
      .wr_data_in(lim_data_in),
      .rd_addr_in(conv_channel_out),
      .rd_data_out(lim)
   );

   // Alarm comparisons in signed 21 bits so limits never wrap
   logic signed [EXT_W-1:0] res_x, hi_set_lim, hi_clr_lim, lo_set_lim, lo_clr_lim;
   logic hi_set, hi_clr, lo_set, lo_clr;

   always_comb begin
      res_x = {3'h0, conv_result_in};
      hi_set_lim = {3'h0, lim.hi_thr} + {3'h0, lim.hi_hyst};
      hi_clr_lim = {3'h0, lim.hi_thr} - {3'h0, lim.hi_hyst} - HI_CLR_OFS;
      lo_set_lim = {3'h0, lim.lo_thr} - {3'h0, lim.lo_hyst} - LO_SET_OFS;
      lo_clr_lim = {3'h0, lim.lo_thr} + {3'h0, lim.lo_hyst} + LO_CLR_OFS;
      hi_set = res_x > hi_set_lim;
      hi_clr = res_x <= hi_clr_lim;
      lo_set = res_x < lo_set_lim;
      lo_clr = res_x >= lo_clr_lim;
   end

   // Alarm flags; a trip arriving with its read wins over the clear
   logic [CH_N-1:0] nxt_act_hi, nxt_act_lo, nxt_trip_hi, nxt_trip_lo;
   logic [RES_W-1:0] nxt_result;
   logic [PV_W-1:0] nxt_lsb;

   always_comb begin
      nxt_act_hi = active_hi_out;
      nxt_act_lo = active_lo_out;
      nxt_trip_hi = tripped_hi_out;
      nxt_trip_lo = tripped_lo_out;
      nxt_result = result_ff;
      nxt_lsb = lsb_step_out;
      if (flag_read_in) begin
         nxt_trip_hi[flag_chan_in] = 1'b0;
         nxt_trip_lo[flag_chan_in] = 1'b0;
      end
      if (conv_valid_in) begin
         nxt_result = conv_result_in;
         nxt_lsb = asfa_lsb_step(conv_range_in);
         // Only the converted channel is judged, on its own limits
         for (int i = 0; i < CH_N; i++) begin
            if (CH_W'(i) == conv_channel_out) begin
               if (hi_set) begin
                  nxt_act_hi[i] = 1'b1;
                  nxt_trip_hi[i] = 1'b1;
               end else if (hi_clr) begin
                  nxt_act_hi[i] = 1'b0;
               end
               if (lo_set) begin
                  nxt_act_lo[i] = 1'b1;
                  nxt_trip_lo[i] = 1'b1;
               end else if (lo_clr) begin
                  nxt_act_lo[i] = 1'b0;
               end
            end
         end
      end
      if (reg_reset_out) begin
         nxt_act_hi = '0;
         nxt_act_lo = '0;
         nxt_trip_hi = '0;
         nxt_trip_lo = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         active_hi_out <= '0;
         active_lo_out <= '0;
         tripped_hi_out <= '0;
         tripped_lo_out <= '0;
         result_ff <= '0;
         lsb_step_out <= LSB_MID_PV;
      end else begin
         active_hi_out <= nxt_act_hi;
         active_lo_out <= nxt_act_lo;
         tripped_hi_out <= nxt_trip_hi;
         tripped_lo_out <= nxt_trip_lo;
         result_ff <= nxt_result;
         lsb_step_out <= nxt_lsb;
      end
   end

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence frame_open_s;
      frame_ok && cs_fall;
   endsequence
   sequence word_done_s;
      edge16;
   endsequence
   sequence judged_s;
      conv_valid_in && !reg_reset_out && !cs_fall;
   endsequence

   conv_start_a: assert property (frame_open_s |=> conv_start_out
      && conv_channel_out == $past(staged_ff)) else $error("conversion start wrong");
   cmd_low_a: assert property (state_ff == FR_CMD |-> sdo_oe_out && !sdo_out)
      else $error("output not low during command");
   msb_out_a: assert property (word_done_s |=> sdo_out == $past(load_word[RES_W-1])
      ##1 (state_ff == FR_DATA)[*1]) else $error("msb not shifted out");
   alarm_hold_a: assert property (!edge16 |=> $stable(alarm_out))
      else $error("alarm moved off edge 16");
   alarm_val_a: assert property (word_done_s |=> alarm_out == $past(any_trip))
      else $error("alarm value wrong");
   cmd_word_a: assert property (word_done_s |=> cmd_valid_out
      && cmd_word_out == $past({cmd_sr_ff[CMD_W-2:0], sdi_s2_ff})) else $error("bad command");
   sdi_ignore_a: assert property (state_ff == FR_DATA |=> $stable(cmd_word_out))
      else $error("input read after edge 16");
   hi_set_a: assert property (judged_s and hi_set |=> active_hi_out[conv_channel_out]
      && tripped_hi_out[conv_channel_out]) else $error("high alarm not set");
   hi_clr_a: assert property (judged_s and !hi_set && hi_clr |=>
      !active_hi_out[conv_channel_out]) else $error("high alarm not cleared");
   lo_set_a: assert property (judged_s and lo_set |=> active_lo_out[conv_channel_out])
      else $error("low alarm not set");
   lo_clr_a: assert property (judged_s and !lo_set && lo_clr |=>
      !active_lo_out[conv_channel_out]) else $error("low alarm not cleared");
   trip_keep_a: assert property (any_trip && !flag_read_in && !reg_reset_out |=> any_trip)
      else $error("trip flag lost");
   abort_a: assert property (frame_ok && cs_rise && state_ff == FR_CMD |=> invalid_out)
      else $error("abort not flagged");
   pd_quiet_a: assert property (power_down_state_out && $past(power_down_state_out)
      |-> !sdo_oe_out && !conv_start_out) else $error("active while powered down");
   rst_clear_a: assert property (reg_reset_out |=> !invalid_out && !any_trip)
      else $error("register reset incomplete");

endmodule

// File: asfa_top_tb.sv
`timescale 1ns/1ps
module asfa_top_tb
   import asfa_pkg::*;
;
   // Clock, reset and counters
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   int fail_count = 0;
   int checks = 0;
   int start_count = 0;
   int rr_count = 0;
   int cv_count = 0;
   logic [RES_W-1:0] next_res = 18'h0;
   // Pins, core side and configuration
   logic cs_n_in, sclk_in, sdi_in, daisy_in, sdo_line, pre_or;
   logic sdo_last = 1'b0;
   logic reset_powerdown_n_in = 1'b1;
   logic conv_valid_in = 1'b0;
   logic [RES_W-1:0] conv_result_in = 18'h0;
   logic [2:0] conv_range_in = 3'h0;
   logic [CH_W-1:0] chan_sel_in = 3'h0;
   logic lim_wr_in = 1'b0;
   logic [CH_W-1:0] lim_chan_in = 3'h0;
   asfa_limits_type lim_data_in = '0;
   logic flag_read_in = 1'b0;
   logic [CH_W-1:0] flag_chan_in = 3'h0;
   logic sdo_out, sdo_oe_out, alarm_out, conv_start_out, cmd_valid_out, invalid_out;
   logic power_down_state_out, reg_reset_out;
   logic [CH_W-1:0] conv_channel_out;
   logic [PV_W-1:0] lsb_step_out;
   logic [CH_N-1:0] active_hi_out, active_lo_out, tripped_hi_out, tripped_lo_out;
   logic [CMD_W-1:0] cmd_word_out;
   logic [19:0] rx;

   always #12.5 clk_in = ~clk_in;

   // Released line shows the inverse of its last level, not a stale copy
   assign sdo_line = sdo_oe_out ? sdo_out : ~sdo_last;

   // Converter core stand-in and event counters
   always @(posedge clk_in) begin
      if (sdo_oe_out) sdo_last <= sdo_out;
      conv_valid_in <= conv_start_out;
      if (conv_start_out) conv_result_in <= next_res;
      if (conv_start_out) start_count <= start_count + 1;
      if (reg_reset_out) rr_count <= rr_count + 1;
      if (cmd_valid_out) cv_count <= cv_count + 1;
   end

   asfa_top asfa_top_inst (
      .clk_in, .reset_in, .cs_n_in, .sclk_in, .sdi_in, .daisy_in,
      .reset_powerdown_n_in, .sdo_out, .sdo_oe_out, .alarm_out,
      .conv_valid_in, .conv_result_in, .conv_range_in, .conv_start_out,
      .conv_channel_out, .lsb_step_out, .chan_sel_in, .lim_wr_in, .lim_chan_in,
      .lim_data_in, .flag_read_in, .flag_chan_in, .active_hi_out, .active_lo_out,
      .tripped_hi_out, .tripped_lo_out, .cmd_word_out, .cmd_valid_out,
      .invalid_out, .power_down_state_out, .reg_reset_out
   );

   asfa_host_model asfa_host_model_inst (
      .clk_in(clk_in), .cs_n_out(cs_n_in), .sclk_out(sclk_in), .sdi_out(sdi_in),
      .daisy_out(daisy_in), .sdo_in(sdo_line), .rx_out(rx), .pre_or_out(pre_or)
   );

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic frame(input logic [CMD_W-1:0] cmd, input int nf, input logic dz);
      asfa_host_model_inst.frame(cmd, nf, dz);
   endtask

   // Limits must settle two cycles before any result uses them
   task automatic set_lim(input logic [2:0] ch, input logic [71:0] lim);
      @(posedge clk_in);
      lim_wr_in <= 1'b1;
      lim_chan_in <= ch;
      lim_data_in <= asfa_limits_type'(lim);
      @(posedge clk_in);
      lim_wr_in <= 1'b0;
      tick(2);
   endtask

   task automatic t_reset();
      check("alarm_rst", alarm_out, 1'b0);
      check("oe_rst", sdo_oe_out, 1'b0);
      check("step_rst", lsb_step_out, 32'h02540be4);
   endtask

   task automatic t_frame();
      set_lim(3'h0, {18'h3fff0, 18'h0, 18'h0, 18'h0});
      next_res = 18'h2a5f3;
      frame(16'ha5c3, 36, 1'b0);
      check("cmd_word", cmd_word_out, 16'ha5c3);
      check("sdo_result", rx[19:2], 18'h2a5f3);
      check("sdo_tail", rx[1:0], 2'b00);
      check("sdo_lead", pre_or, 1'b0);
      check("oe_idle", sdo_oe_out, 1'b0);
      check("starts", start_count, 1);
      check("cmd_pulses", cv_count, 1);
   endtask

   task automatic t_ranges();
      logic [2:0] rng [5] = '{RNG_BI_2P5, RNG_BI_1P25, RNG_BI_0P625, RNG_UNI_2P5,
                               RNG_UNI_1P25};
      // Steps in picovolts: 78.125, 39.0625 and 19.53125 uV
      logic [PV_W-1:0] stp [5] = '{32'h04a817c8, 32'h02540be4, 32'h012a05f2, 32'h02540be4,
                                   32'h012a05f2};
      for (int i = 0; i < 5; i++) begin
         conv_range_in <= rng[i];
         frame(16'h0000, 16, 1'b0);
         check("lsb_step", lsb_step_out, stp[i]);
      end
   endtask

   // Walk both hysteresis bands across their exact boundaries
   task automatic t_alarm();
      logic [17:0] res [9] = '{18'h1f4, 18'h3f2, 18'h3f3, 18'h3dd, 18'h3dc, 18'h5e,
                               18'h5d, 18'h69, 18'h6a};
      logic [8:0] ahi = 9'h00c;
      logic [8:0] alo = 9'h0c0;
      logic [8:0] thi = 9'h01c;
      logic [8:0] tlo = 9'h1c0;
      logic [8:0] alm = 9'h1dc;
      set_lim(3'h0, {18'h3e8, 18'ha, 18'h64, 18'h5});
      for (int i = 0; i < 9; i++) begin
         next_res = res[i];
         frame(16'h0000, 16, 1'b0);
         check("active_hi", active_hi_out[0], ahi[i]);
         check("active_lo", active_lo_out[0], alo[i]);
         check("tripped_hi", tripped_hi_out[0], thi[i]);
         check("tripped_lo", tripped_lo_out[0], tlo[i]);
         check("alarm", alarm_out, alm[i]);
         if (i == 4) begin
            @(posedge clk_in);
            flag_read_in <= 1'b1;
            flag_chan_in <= 3'h0;
            @(posedge clk_in);
            flag_read_in <= 1'b0;
            tick(2);
            check("trip_read", tripped_hi_out[0], 1'b0);
            check("alarm_hold", alarm_out, 1'b1);
         end
      end
   endtask

   task automatic t_chan();
      set_lim(3'h3, {18'h32, 18'h0, 18'h0, 18'h0});
      chan_sel_in <= 3'h3;
      next_res = 18'h1f4;
      frame(16'h0000, 16, 1'b0);
      check("chan_now", conv_channel_out, 3'h0);
      next_res = 18'h33;
      frame(16'h0000, 16, 1'b0);
      check("chan_next", conv_channel_out, 3'h3);
      check("ch3_hi", active_hi_out, 8'h08);
   endtask

   task automatic t_abort();
      frame(16'hffff, 5, 1'b0);
      check("invalid", invalid_out, 1'b1);
      frame(16'h0000, 34, 1'b0);
      check("invalid_data", rx[17:0], INVALID_FILL);
      check("invalid_end", invalid_out, 1'b0);
   endtask

   task automatic t_daisy();
      next_res = 18'h1;
      frame(16'h0000, 36, 1'b1);
      check("chain_bits", rx, 20'h00007);
   endtask

   task automatic t_rstpin();
      int r0;
      int s0;
      r0 = rr_count;
      reset_powerdown_n_in <= 1'b0;
      tick(3);
      reset_powerdown_n_in <= 1'b1;
      tick(8);
      check("reg_reset", rr_count - r0, 1);
      check("chan_clear", conv_channel_out, 3'h0);
      check("no_pd", power_down_state_out, 1'b0);
      reset_powerdown_n_in <= 1'b0;
      tick(20);
      check("pd_on", power_down_state_out, 1'b1);
      s0 = start_count;
      frame(16'h1234, 16, 1'b0);
      check("pd_starts", start_count - s0, 0);
      check("pd_cmd", cmd_word_out == 16'h1234, 1'b0);
      reset_powerdown_n_in <= 1'b1;
      tick(8);
      check("pd_off", power_down_state_out, 1'b0);
      check("pd_reset", rr_count - r0, 2);
      // Configure again, then convert on the defaulted channel
      set_lim(3'h0, {18'h3e8, 18'ha, 18'h64, 18'h5});
      frame(16'h0000, 34, 1'b0);
      check("pd_resume", start_count - s0, 1);
      check("pd_data", rx[17:0], 18'h00001);
   endtask

   // Watchdog well beyond the expected run of about 3800 cycles
   initial begin
      tick(40000);
      fail_count++;
      summarize();
   end

   // Main sequence
   initial begin
      tick(8);
      reset_in <= 1'b0;
      tick(4);
      t_reset();
      t_frame();
      t_ranges();
      t_alarm();
      t_chan();
      t_abort();
      t_daisy();
      t_rstpin();
      summarize();
   end
endmodule
